// >>> rtl/ppp_pkg.sv
package ppp_pkg;
	// Interface modes, fixed by static configuration
	typedef enum logic [1:0] {
		PPP_MODE_ASYNC_MUX = 2'h0,
		PPP_MODE_SYNC_MUX = 2'h1,
		PPP_MODE_SYNC_FIFO = 2'h2
	} ppp_mode_t;

	// Flag kinds
	localparam logic [1:0] PPP_FLAG_EMPTY = 2'h0;
	localparam logic [1:0] PPP_FLAG_FULL = 2'h1;
	localparam logic [1:0] PPP_FLAG_PARTIAL = 2'h2;

	localparam int PPP_DATA_W = 16;
	localparam int PPP_ADDR_W = 8;
	localparam int PPP_SEL_W = 2;
	localparam int PPP_THREADS = 4;
	localparam int PPP_DEPTH_W = 4;
	localparam int PPP_DEPTH = 16;
	localparam int PPP_MEM_W = 4;
	localparam int PPP_FLAG_CNT = 2;

	// Fixed access latencies in link clock cycles
	localparam logic [1:0] PPP_LAT_NORMAL = 2'h2;
	localparam logic [1:0] PPP_LAT_FAST = 2'h1;
	localparam logic [1:0] PPP_WR_TAIL = 2'h3;
	localparam int PPP_SEL_PIPE = 3;
	localparam logic [PPP_DEPTH_W:0] PPP_PARTIAL_LEVEL = 5'h08;
	localparam logic [PPP_DEPTH_W:0] PPP_FULL_LEVEL = 5'h10;
	localparam logic [3:0] PPP_BURST_DEF = 4'h4;
endpackage : ppp_pkg

// >>> rtl/ppp_port.sv
// Function
// - Async reads may repeat under held select
// - Async read ends at first OE/CS release
// - Async writes may repeat under held select
// - Async write captured at first WE/CS release
// - Sync modes launch and sample same edge
// - Ready two after OE, drops after data
// - Read data two after OE, held
// - Write ready two after WE, drops three
// - Latency two; one-cycle option below 50MHz
// - Write bursts whole; read ready drops early only on OE/CS release
// - Burst write ready drops three after last
// - FIFO OE only gates bus drive
// - Read strobe edge advances pointer, new word
// - Burst read advances every strobed edge
// - OE before read shows current word
// - Write strobe with select stores, advances
// - Flags update after accepted write edge
// - Packet end without write commits empty
// - Flags configurable kind and thread
// - Address change seen three cycles later
`timescale 1ns/1ps
`default_nettype none
module ppp_port (
	input wire logic i_sys_clk, // System clock (core side)
	input wire logic i_rst, // Synchronous reset, high
	input wire logic i_link_clk, // Interface clock from host
	input wire logic [1:0] i_mode, // Static interface mode
	input wire logic i_fast_lat, // One-cycle latency option
	input wire logic [3:0] i_burst_len, // Burst length in words, 0 = single
	input wire logic [1:0] i_flag_kind [2], // Per-flag kind
	input wire logic i_flag_dedicated [2], // Per-flag thread is fixed
	input wire logic [1:0] i_flag_thread [2], // Per-flag fixed thread
	input wire logic i_address_latch_valid_n, // Address latch strobe
	input wire logic i_ce_n, // Mux mode chip select
	input wire logic i_oe_n, // Mux mode output enable
	input wire logic i_we_n, // Mux mode write enable
	input wire logic i_fifo_chip_select_n, // FIFO select
	input wire logic i_fifo_output_enable_n, // FIFO bus drive enable
	input wire logic i_fifo_read_strobe_n, // FIFO read strobe
	input wire logic i_fifo_write_strobe_n, // FIFO write strobe
	input wire logic i_packet_commit_n, // Packet end
	input wire logic [1:0] i_fifo_select_lines, // FIFO thread address
	input wire logic [15:0] i_dq, // Data bus in
	output logic [15:0] o_dq, // Data bus out
	output logic o_dq_oe_n, // Data bus drive, low = drive
	output logic o_rdy, // Sync mux ready
	output logic o_flag [2], // FIFO flags
	output logic o_pkt_pulse, // Packet committed (sys clock)
	output logic o_zlp_pulse, // Empty packet committed (sys clock)
	output logic [1:0] o_pkt_thread // Thread of last commit
);
	//------------------------------
	// Async input synchronisers
	//------------------------------
	logic [3:0] async_s1_reg;
	logic [3:0] async_s2_reg;
	logic [3:0] async_prev_reg;
	logic [15:0] dq_s1_reg;
	logic [15:0] dq_s2_reg;
	always_ff @(posedge i_sys_clk) begin
		async_s1_reg <= {i_address_latch_valid_n, i_ce_n, i_oe_n, i_we_n};
		async_s2_reg <= async_s1_reg;
		dq_s1_reg <= i_dq;
		dq_s2_reg <= dq_s1_reg;
	end
	wire a_adv_n = async_s2_reg[3];
	wire a_ce_n = async_s2_reg[2];
	wire a_oe_n = async_s2_reg[1];
	wire a_we_n = async_s2_reg[0];
	wire a_rd_act = !a_ce_n && !a_oe_n;
	wire a_wr_act = !a_ce_n && !a_we_n;
	wire a_rd_prev = !async_prev_reg[2] && !async_prev_reg[1];
	wire a_wr_prev = !async_prev_reg[2] && !async_prev_reg[0];
	wire async_mode = i_mode == ppp_pkg::PPP_MODE_ASYNC_MUX;
	wire a_rd_end = async_mode && a_rd_prev && !a_rd_act;
	wire a_wr_end = async_mode && a_wr_prev && !a_wr_act;
	wire a_adv_rise = async_mode && !async_prev_reg[3] && a_adv_n;

	//------------------------------
	// Async mux storage (system clock)
	//------------------------------
	logic [7:0] a_addr_reg;
	logic [15:0] a_mem_reg [16];
	logic [15:0] a_rdata_reg;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			async_prev_reg <= 4'hF;
			a_addr_reg <= 8'h00;
			a_rdata_reg <= 16'h0000;
		end else begin
			async_prev_reg <= async_s2_reg;
			if (a_adv_rise)
				a_addr_reg <= dq_s2_reg[7:0];
			if (a_wr_end)
				a_mem_reg[a_addr_reg[3:0]] <= dq_s2_reg;
			a_rdata_reg <= a_mem_reg[a_addr_reg[3:0]];
		end
	end

	//------------------------------
	// Link clock reset
	//------------------------------
	logic lrst_s1_reg;
	logic lrst_reg;
	always_ff @(posedge i_link_clk) begin
		lrst_s1_reg <= i_rst;
		lrst_reg <= lrst_s1_reg;
	end

	//------------------------------
	// Sync mux engine (link clock)
	//------------------------------
	typedef enum logic [2:0] {PPP_IDLE, PPP_RD_WAIT, PPP_RD_DATA, PPP_WR_WAIT, PPP_WR_DATA,
		PPP_WR_TAIL} ppp_state_t;
	ppp_state_t st_reg;
	logic [1:0] cnt_reg;
	logic [3:0] beat_reg;
	logic [7:0] s_addr_reg;
	logic [15:0] s_mem_reg [16];
	logic rdy_reg;
	logic [15:0] l_dq_reg;
	logic l_drive_reg;
	wire sync_mode = i_mode == ppp_pkg::PPP_MODE_SYNC_MUX;
	wire [1:0] lat = i_fast_lat ? ppp_pkg::PPP_LAT_FAST : ppp_pkg::PPP_LAT_NORMAL;
	wire [3:0] blen = (i_burst_len == 4'h0) ? 4'h1 : i_burst_len;
	wire last_beat = beat_reg == blen - 4'h1;
	wire [3:0] s_idx = s_addr_reg[3:0] + beat_reg;

	// Samples and launches on the rising edge, where the host samples
	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			st_reg <= PPP_IDLE;
			cnt_reg <= 2'h0;
			beat_reg <= 4'h0;
			s_addr_reg <= 8'h00;
			rdy_reg <= 1'b0;
		end else begin
			unique case (st_reg)
				PPP_IDLE: begin
					beat_reg <= 4'h0;
					cnt_reg <= 2'h1;
					if (sync_mode && !i_address_latch_valid_n)
						s_addr_reg <= i_dq[7:0];
					// One-cycle latency skips the wait state
					if (sync_mode && !i_ce_n && !i_oe_n) begin
						st_reg <= (lat == 2'h1) ? PPP_RD_DATA : PPP_RD_WAIT;
						rdy_reg <= lat == 2'h1;
					end else if (sync_mode && !i_ce_n && !i_we_n) begin
						st_reg <= (lat == 2'h1) ? PPP_WR_DATA : PPP_WR_WAIT;
						rdy_reg <= lat == 2'h1;
					end
				end
				PPP_RD_WAIT: begin
					cnt_reg <= cnt_reg + 2'h1;
					if (cnt_reg + 2'h1 == lat)
						rdy_reg <= 1'b1;
					if (cnt_reg >= lat - 2'h1)
						st_reg <= PPP_RD_DATA;
				end
				PPP_RD_DATA: begin
					// Ready drops only at the last beat or on OE/CE release
					if (last_beat)
						rdy_reg <= 1'b0;
					else
						beat_reg <= beat_reg + 4'h1;
					if (i_oe_n || i_ce_n) begin
						st_reg <= PPP_IDLE;
						rdy_reg <= 1'b0;
					end
				end
				PPP_WR_WAIT: begin
					cnt_reg <= cnt_reg + 2'h1;
					if (cnt_reg + 2'h1 == lat)
						rdy_reg <= 1'b1;
					if (cnt_reg >= lat - 2'h1)
						st_reg <= PPP_WR_DATA;
				end
				PPP_WR_DATA: begin
					s_mem_reg[s_idx] <= i_dq;
					beat_reg <= beat_reg + 4'h1;
					cnt_reg <= 2'h1;
					if (last_beat)
						st_reg <= PPP_WR_TAIL;
				end
				PPP_WR_TAIL: begin
					cnt_reg <= cnt_reg + 2'h1;
					if (cnt_reg == ppp_pkg::PPP_WR_TAIL - 2'h1) begin
						rdy_reg <= 1'b0;
						st_reg <= PPP_IDLE;
					end
				end
			endcase
		end
	end

	//------------------------------
	// Slave FIFO (link clock)
	//------------------------------
	logic [15:0] f_mem_reg [4][16];
	logic [4:0] f_wp_reg [4];
	logic [4:0] f_rp_reg [4];
	logic [1:0] sel_pipe_reg [3];
	logic [1:0] pkt_thr_reg;
	logic pkt_tgl_reg;
	logic zlp_tgl_reg;
	logic flag_reg [2];
	wire fifo_mode = i_mode == ppp_pkg::PPP_MODE_SYNC_FIFO;
	wire [1:0] thr = sel_pipe_reg[ppp_pkg::PPP_SEL_PIPE - 1];
	wire f_cs = fifo_mode && !i_fifo_chip_select_n;
	wire f_wr = f_cs && !i_fifo_write_strobe_n;
	wire f_rd = f_cs && !i_fifo_read_strobe_n;
	wire f_pe = f_cs && !i_packet_commit_n;

	function automatic logic [4:0] level(input logic [4:0] wp, input logic [4:0] rp);
		level = wp - rp;
	endfunction : level

	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			for (int t = 0; t < 4; t++) begin
				f_wp_reg[t] <= 5'h00;
				f_rp_reg[t] <= 5'h00;
			end
			for (int p = 0; p < 3; p++)
				sel_pipe_reg[p] <= 2'h0;
			pkt_thr_reg <= 2'h0;
			pkt_tgl_reg <= 1'b0;
			zlp_tgl_reg <= 1'b0;
		end else begin
			sel_pipe_reg[0] <= i_fifo_select_lines;
			sel_pipe_reg[1] <= sel_pipe_reg[0];
			sel_pipe_reg[2] <= sel_pipe_reg[1];
			if (f_wr && level(f_wp_reg[thr], f_rp_reg[thr]) != ppp_pkg::PPP_FULL_LEVEL) begin
				f_mem_reg[thr][f_wp_reg[thr][3:0]] <= i_dq;
				f_wp_reg[thr] <= f_wp_reg[thr] + 5'h01;
			end
			if (f_rd && f_wp_reg[thr] != f_rp_reg[thr])
				f_rp_reg[thr] <= f_rp_reg[thr] + 5'h01;
			if (f_pe) begin
				pkt_thr_reg <= thr;
				if (f_wr)
					pkt_tgl_reg <= !pkt_tgl_reg;
				else
					zlp_tgl_reg <= !zlp_tgl_reg;
			end
		end
	end

	// Flags follow the pointers one edge later
	always_ff @(posedge i_link_clk) begin
		for (int f = 0; f < ppp_pkg::PPP_FLAG_CNT; f++) begin
			logic [1:0] ft;
			logic [4:0] lv;
			ft = i_flag_dedicated[f] ? i_flag_thread[f] : thr;
			lv = level(f_wp_reg[ft], f_rp_reg[ft]);
			if (lrst_reg)
				flag_reg[f] <= 1'b0;
			else if (i_flag_kind[f] == ppp_pkg::PPP_FLAG_EMPTY)
				flag_reg[f] <= lv == 5'h00;
			else if (i_flag_kind[f] == ppp_pkg::PPP_FLAG_FULL)
				flag_reg[f] <= lv == ppp_pkg::PPP_FULL_LEVEL;
			else
				flag_reg[f] <= lv >= ppp_pkg::PPP_PARTIAL_LEVEL;
		end
	end

	//------------------------------
	// Link-side bus drive
	//------------------------------
	wire [15:0] f_word = f_mem_reg[thr][f_rp_reg[thr][3:0]];
	wire [15:0] f_next = f_mem_reg[thr][f_rp_reg[thr][3:0] + 4'h1];
	wire rd_drive = (st_reg == PPP_RD_DATA) && !i_oe_n;
	// First word launches on the edge that raises ready
	wire rd_load = (st_reg == PPP_IDLE && sync_mode && !i_ce_n && !i_oe_n && lat == 2'h1)
		|| (st_reg == PPP_RD_WAIT && cnt_reg >= lat - 2'h1);
	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			l_dq_reg <= 16'h0000;
			l_drive_reg <= 1'b0;
		end else if (fifo_mode) begin
			l_dq_reg <= f_rd ? f_next : f_word;
			l_drive_reg <= f_cs && !i_fifo_output_enable_n;
		end else begin
			if (rd_load)
				l_dq_reg <= s_mem_reg[s_addr_reg[3:0]];
			else if (st_reg == PPP_RD_DATA && !last_beat)
				l_dq_reg <= s_mem_reg[s_idx + 4'h1];
			l_drive_reg <= rd_drive || rd_load;
		end
	end

	//------------------------------
	// Commit events to system clock
	//------------------------------
	logic [2:0] pkt_sync_reg;
	logic [2:0] zlp_sync_reg;
	logic pkt_pulse_reg;
	logic zlp_pulse_reg;
	logic [1:0] pkt_thread_reg;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pkt_sync_reg <= 3'h0;
			zlp_sync_reg <= 3'h0;
			pkt_pulse_reg <= 1'b0;
			zlp_pulse_reg <= 1'b0;
			pkt_thread_reg <= 2'h0;
		end else begin
			pkt_sync_reg <= {pkt_sync_reg[1:0], pkt_tgl_reg};
			zlp_sync_reg <= {zlp_sync_reg[1:0], zlp_tgl_reg};
			pkt_pulse_reg <= pkt_sync_reg[2] ^ pkt_sync_reg[1];
			zlp_pulse_reg <= zlp_sync_reg[2] ^ zlp_sync_reg[1];
			// Thread is stable long before the toggle is seen
			if ((pkt_sync_reg[2] ^ pkt_sync_reg[1]) || (zlp_sync_reg[2] ^ zlp_sync_reg[1]))
				pkt_thread_reg <= pkt_thr_reg;
		end
	end

	//------------------------------
	// Outputs
	//------------------------------
	// Async bus drive on system clock; link drive otherwise
	logic [15:0] dq_out_reg;
	logic dq_oe_n_reg;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			dq_out_reg <= 16'h0000;
			dq_oe_n_reg <= 1'b1;
		end else begin
			dq_out_reg <= a_rdata_reg;
			dq_oe_n_reg <= !(async_mode && a_rd_act);
		end
	end
	assign o_dq = async_mode ? dq_out_reg : l_dq_reg;
	assign o_dq_oe_n = async_mode ? dq_oe_n_reg : !l_drive_reg;
	assign o_rdy = rdy_reg;
	assign o_flag = flag_reg;
	assign o_pkt_pulse = pkt_pulse_reg;
	assign o_zlp_pulse = zlp_pulse_reg;
	assign o_pkt_thread = pkt_thread_reg;
endmodule : ppp_port
`default_nettype wire

// >>> bench/ppp_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_port_sva (
	input wire logic i_rst, // Reset
	input wire logic i_link_clk, // Link clock
	input wire logic [1:0] i_mode, // Mode
	input wire logic i_fast_lat, // Short latency
	input wire logic i_ce_n, // Mux select
	input wire logic i_oe_n, // Mux read
	input wire logic i_we_n, // Mux write
	input wire logic i_fifo_chip_select_n, // FIFO select
	input wire logic i_fifo_output_enable_n, // FIFO drive
	input wire logic o_dq_oe_n, // Bus drive
	input wire logic o_rdy // Ready
);
	wire sm = i_mode == 2'h1;
	wire sf = i_mode == 2'h2;
	default clocking @(posedge i_link_clk); endclocking
	default disable iff (i_rst);
	rd_lat_a: assert property (sm && !i_fast_lat && !i_ce_n && $fell(i_oe_n) |-> ##[2:3] o_rdy)
		else $error("read ready late");
	fast_lat_a: assert property (sm && i_fast_lat && !i_ce_n && $fell(i_oe_n) |-> ##[1:2] o_rdy)
		else $error("fast ready late");
	wr_lat_a: assert property (sm && !i_fast_lat && !i_ce_n && $fell(i_we_n) |-> ##[2:3] o_rdy)
		else $error("write ready late");
	rdy_drop_a: assert property ((sm && i_oe_n && i_we_n)[*5] |-> !o_rdy)
		else $error("ready stuck high");
	rdy_cause_a: assert property ($rose(o_rdy) |-> sm && (!$past(i_oe_n) || !$past(i_we_n)))
		else $error("ready without strobe");
	rd_drive_a: assert property (sm && !i_oe_n && o_rdy |-> !o_dq_oe_n)
		else $error("ready without data");
	fifo_off_a: assert property ((sf && i_fifo_output_enable_n)[*3] |-> o_dq_oe_n)
		else $error("fifo bus still driven");
	fifo_on_a: assert property ((sf && !i_fifo_chip_select_n && !i_fifo_output_enable_n)[*3]
		|-> !o_dq_oe_n)
		else $error("fifo bus not driven");
	cover property (sm && o_rdy && !i_we_n);
	cover property (sm && o_rdy && !i_oe_n);
	cover property (sf && !o_dq_oe_n);
endmodule : ppp_port_sva
bind ppp_port ppp_port_sva u_sva (.i_rst, .i_link_clk, .i_mode, .i_fast_lat, .i_ce_n, .i_oe_n,
	.i_we_n, .i_fifo_chip_select_n, .i_fifo_output_enable_n, .o_dq_oe_n, .o_rdy);
`default_nettype wire

// >>> bench/ppp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_host_model (
	input wire logic i_rdy, // Ready
	input wire logic [15:0] i_dq, // Device data
	output logic o_link_clk = 1'b0, // Link clock
	output logic o_adv_n = 1'b1, // Address strobe
	output logic o_ce_n = 1'b1, // Mux select
	output logic o_oe_n = 1'b1, // Mux read
	output logic o_we_n = 1'b1, // Mux write
	output logic o_cs_n = 1'b1, // FIFO select
	output logic o_foe_n = 1'b1, // FIFO drive
	output logic o_rd_n = 1'b1, // FIFO read
	output logic o_wr_n = 1'b1, // FIFO write
	output logic o_pkt_n = 1'b1, // Packet end
	output logic [1:0] o_sel = 2'h0, // FIFO thread
	output logic [15:0] o_dq = 16'h0000 // Host data
);
	logic [15:0] buf_q [16];
	always #32 o_link_clk = ~o_link_clk;
	// Released data lines show the inverse of their last value
	task automatic amux(input logic wr, input logic [3:0] a, inout logic [15:0] d, input logic ce_end);
		o_ce_n = 1'b0;
		o_dq = {12'h000, a};
		o_adv_n = 1'b0;
		#40 o_adv_n = 1'b1;
		#30 o_dq = wr ? d : ~o_dq;
		o_we_n = !wr;
		o_oe_n = wr;
		#80 d = wr ? d : i_dq;
		o_ce_n = ce_end;
		#20 o_we_n = 1'b1;
		o_oe_n = 1'b1;
		#20 o_dq = ~o_dq;
		#40;
	endtask : amux
	task automatic smux(input logic wr, input logic [7:0] a, input int n);
		int k = 0;
		@(negedge o_link_clk);
		o_ce_n = 1'b0;
		o_adv_n = 1'b0;
		o_dq = {8'h00, a};
		@(negedge o_link_clk);
		o_adv_n = 1'b1;
		o_dq = wr ? buf_q[0] : ~o_dq;
		o_we_n = !wr;
		o_oe_n = wr;
		for (int t = 0; t < 40 && k < n; t++) begin
			@(posedge o_link_clk);
			if (i_rdy === 1'b1) begin
				if (!wr) buf_q[k] = i_dq;
				k++;
			end
			@(negedge o_link_clk);
			o_dq = wr ? buf_q[k] : ~o_dq;
		end
		o_we_n = 1'b1;
		o_oe_n = 1'b1;
		o_ce_n = 1'b1;
	endtask : smux
	task automatic fwr(input logic [1:0] s, input int n, input logic pkt);
		o_cs_n = 1'b0;
		o_sel = s;
		repeat (4) @(negedge o_link_clk);
		for (int k = 0; k < n; k++) begin
			o_dq = buf_q[k];
			o_wr_n = 1'b0;
			o_pkt_n = !(pkt && k == n - 1);
			@(negedge o_link_clk);
		end
		o_wr_n = 1'b1;
		o_dq = ~o_dq;
		o_pkt_n = !(pkt && n == 0);
		@(negedge o_link_clk);
		o_pkt_n = 1'b1;
	endtask : fwr
endmodule : ppp_host_model
`default_nettype wire

// >>> bench/test_parallel_processor_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_parallel_processor_port;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [1:0] i_mode = 2'h0;
	logic i_fast_lat = 1'b0;
	logic [3:0] i_burst_len = 4'h4;
	logic [1:0] i_flag_kind [2] = '{2'h0, 2'h2};
	logic i_flag_dedicated [2] = '{1'b1, 1'b0};
	logic [1:0] i_flag_thread [2] = '{2'h0, 2'h0};
	wire i_link_clk, i_address_latch_valid_n, i_ce_n, i_oe_n, i_we_n, i_fifo_chip_select_n;
	wire i_fifo_output_enable_n, i_fifo_read_strobe_n, i_fifo_write_strobe_n, i_packet_commit_n;
	wire [1:0] i_fifo_select_lines, o_pkt_thread;
	wire [15:0] i_dq, o_dq;
	wire o_dq_oe_n, o_rdy, o_pkt_pulse, o_zlp_pulse;
	logic o_flag [2];
	int err_total = 0;
	int n_tests = 0;
	int pkts = 0;
	int zlps = 0;
	logic [31:0] seed = 32'h2022;
	always #2.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		pkts <= pkts + int'(o_pkt_pulse === 1'b1);
		zlps <= zlps + int'(o_zlp_pulse === 1'b1);
	end
	ppp_port uut (.i_sys_clk, .i_rst, .i_link_clk, .i_mode, .i_fast_lat, .i_burst_len,
		.i_flag_kind, .i_flag_dedicated, .i_flag_thread, .i_address_latch_valid_n, .i_ce_n,
		.i_oe_n, .i_we_n, .i_fifo_chip_select_n, .i_fifo_output_enable_n, .i_fifo_read_strobe_n,
		.i_fifo_write_strobe_n, .i_packet_commit_n, .i_fifo_select_lines, .i_dq, .o_dq,
		.o_dq_oe_n, .o_rdy, .o_flag, .o_pkt_pulse, .o_zlp_pulse, .o_pkt_thread);
	ppp_host_model host (.i_rdy(o_rdy), .i_dq(o_dq), .o_link_clk(i_link_clk),
		.o_adv_n(i_address_latch_valid_n), .o_ce_n(i_ce_n), .o_oe_n(i_oe_n), .o_we_n(i_we_n),
		.o_cs_n(i_fifo_chip_select_n), .o_foe_n(i_fifo_output_enable_n),
		.o_rd_n(i_fifo_read_strobe_n), .o_wr_n(i_fifo_write_strobe_n),
		.o_pkt_n(i_packet_commit_n), .o_sel(i_fifo_select_lines), .o_dq(i_dq));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk_w
	task automatic chk_b(input string nm, input logic e, input logic g);
		chk_w(nm, {15'h0000, e}, {15'h0000, g});
	endtask : chk_b
	task automatic lw(input int n);
		repeat (n) @(negedge i_link_clk);
	endtask : lw
	task automatic rst(input logic [1:0] m);
		@(negedge i_sys_clk);
		i_rst = 1'b1;
		i_mode = m;
		repeat (60) @(negedge i_sys_clk);
		i_rst = 1'b0;
		lw(5);
	endtask : rst
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial begin
		#100000;
		err_total++;
		$display("unexpected timeout: expected done, seen hang");
		test_done;
	end
	initial begin
		logic [15:0] w [16];
		logic [15:0] d;
		logic [1:0] t;
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			w[k] = seed[15:0];
		end
		rst(2'h0);
		for (int k = 0; k < 8; k++) begin
			d = w[k % 4];
			host.amux(k < 4, 4'((k % 4) * 5), d, k % 4 == 3);
			if (k > 3) chk_w("async word", w[k - 4], d);
		end
		$display("async mux done");
		rst(2'h1);
		for (int k = 0; k < 4; k++) host.buf_q[k] = w[k + 4];
		host.smux(1'b1, 8'h0C, 4);
		for (int k = 0; k < 4; k++) host.buf_q[k] = ~w[k + 4];
		lw(4);
		host.smux(1'b0, 8'h0C, 4);
		for (int k = 0; k < 4; k++) chk_w("sync word", w[k + 4], host.buf_q[k]);
		@(negedge i_sys_clk);
		i_fast_lat = 1'b1;
		for (int k = 0; k < 4; k++) host.buf_q[k] = ~w[k + 4];
		lw(4);
		host.smux(1'b0, 8'h0C, 4);
		for (int k = 0; k < 4; k++) chk_w("fast word", w[k + 4], host.buf_q[k]);
		$display("sync mux done");
		t = seed[17:16];
		i_flag_thread = '{t, t};
		rst(2'h2);
		chk_b("empty flag", 1'b1, o_flag[0]);
		for (int k = 0; k < 8; k++) host.buf_q[k] = w[k + 8];
		host.fwr(t, 8, 1'b1);
		lw(4);
		chk_b("empty flag", 1'b0, o_flag[0]);
		chk_b("partial flag", 1'b1, o_flag[1]);
		chk_w("commit thread", {14'h0000, t}, {14'h0000, o_pkt_thread});
		chk_w("commit count", 16'h0001, 16'(pkts));
		host.o_sel = t + 2'h1;
		lw(2);
		chk_b("partial flag", 1'b1, o_flag[1]);
		lw(2);
		chk_b("partial flag", 1'b0, o_flag[1]);
		chk_b("empty flag", 1'b0, o_flag[0]);
		host.o_sel = t;
		host.o_foe_n = 1'b0;
		lw(4);
		host.o_foe_n = 1'b1;
		lw(2);
		host.o_foe_n = 1'b0;
		lw(3);
		chk_w("first word", w[8], o_dq);
		host.o_rd_n = 1'b0;
		lw(3);
		host.o_rd_n = 1'b1;
		lw(3);
		chk_w("burst word", w[11], o_dq);
		chk_b("partial flag", 1'b0, o_flag[1]);
		host.fwr(t, 0, 1'b1);
		lw(4);
		chk_w("empty commits", 16'h0001, 16'(zlps));
		$display("slave fifo done");
		test_done;
	end
endmodule : test_parallel_processor_port
`default_nettype wire
